// >>> sdec_pkg.sv
// Package with register map, field layout and timing constants of the SDRAM ECC/reset control block.
package sdec_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index).
  // ==========================================================================
  localparam logic [11:0] IDX_ECC_CONTROL     = 12'h020;
  localparam logic [11:0] IDX_ECC_STATUS      = 12'h021;
  localparam logic [11:0] IDX_ECC_BIT_POS     = 12'h022;
  localparam logic [11:0] IDX_ECC_SINGLE_ADDR = 12'h024;
  localparam logic [11:0] IDX_ECC_MULTI_ADDR  = 12'h028;
  localparam logic [11:0] IDX_SDRAM_CONTROL   = 12'h030;
  localparam logic [11:0] IDX_RESET_CONFIG    = 12'hD72;
  localparam int          APB_AW              = 14;

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int CTL_ECC_ENABLE  = 0;
  localparam int CTL_SINGLE_IRQ  = 1;
  localparam int CTL_MULTI_IRQ   = 2;
  localparam int CTL_REARM       = 3;
  localparam int STA_SINGLE      = 0;
  localparam int STA_MULTI       = 1;
  localparam int SDC_REF_ENABLE  = 0;
  localparam int SDC_REF_RATE_LO = 1;
  localparam int SDC_WB_ENABLE   = 3;
  localparam int SDC_RA_ENABLE   = 4;
  localparam int RCF_RET_ENABLE  = 0;

  // ==========================================================================
  // Reset values.
  // ==========================================================================
  localparam logic [3:0] ECC_CONTROL_RST   = 4'h0;
  localparam logic [4:0] SDRAM_CONTROL_RST = 5'h00;
  localparam logic       RESET_CONFIG_RST  = 1'b0;
  localparam logic [3:0] BE_FULL           = 4'hF;

  // ==========================================================================
  // Refresh timing at a 10 ns clock.
  // ==========================================================================
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real T_REF0_US     = 7.8;
  localparam real T_REF1_US     = 15.6;
  localparam real T_REF2_US     = 31.2;
  localparam real T_REF3_US     = 62.5;
  localparam int  REF0_CYC = int'($floor(T_REF0_US * 1000.0 / CLK_PERIOD_NS + 0.001));
  localparam int  REF1_CYC = int'($floor(T_REF1_US * 1000.0 / CLK_PERIOD_NS + 0.001));
  localparam int  REF2_CYC = int'($floor(T_REF2_US * 1000.0 / CLK_PERIOD_NS + 0.001));
  localparam int  REF3_CYC = int'($floor(T_REF3_US * 1000.0 / CLK_PERIOD_NS + 0.001));
  localparam int  REF_CW   = 13;

  // Commands handed to the SDRAM timing engine.
  typedef enum logic [1:0] {
    SDEC_CMD_NONE,
    SDEC_CMD_READ,
    SDEC_CMD_WRITE,
    SDEC_CMD_REFRESH
  } sdec_cmd_t;

endpackage : sdec_pkg

// >>> sdec_refresh_if.sv
// Interface joining the controller to its refresh interval timer.
interface sdec_refresh_if;
  logic       enable;
  logic [1:0] rate;
  logic       req;
  logic       ack;
  modport timer (input enable, input rate, input ack, output req);
  modport ctrl  (output enable, output rate, output ack, input req);
endinterface : sdec_refresh_if

// >>> sdec_refresh_timer.sv
// Refresh interval timer with four selectable periods.
module sdec_refresh_timer
  import sdec_pkg::*;
#(
  parameter int P_REF3_CYC = REF3_CYC
) (
  input  wire logic      pclk,
  input  wire logic      presetn,
  sdec_refresh_if.timer  rif
);

  logic [REF_CW-1:0] count;
  logic [REF_CW-1:0] limit;

  // Selects the terminal count of the chosen interval.
  always_comb begin
    case (rif.rate)
      2'd0:    limit = REF_CW'(REF0_CYC - 1);
      2'd1:    limit = REF_CW'(REF1_CYC - 1);
      2'd2:    limit = REF_CW'(REF2_CYC - 1);
      default: limit = REF_CW'(P_REF3_CYC - 1);
    endcase
  end

  // Free running period counter; the period does not depend on when refresh is served.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (!rif.enable || count >= limit) begin
      count <= '0;
    end else begin
      count <= count + REF_CW'(1);
    end
  end

  // Pending refresh request; a new tick wins over the acknowledge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rif.req <= 1'b0;
    end else if (rif.enable && count >= limit) begin
      rif.req <= 1'b1; // RQ12
    end else if (rif.ack || !rif.enable) begin
      rif.req <= 1'b0;
    end
  end

endmodule : sdec_refresh_timer

// >>> sdec_ctrl.sv
// SDRAM controller core for ECC error capture, write protection, refresh and reset retention.
// Operation
// RQ1: Single-bit error raises maskable interrupt.
// RQ2: Multi-bit error raises non-maskable interrupt.
// RQ3: Separate single and multi error flags.
// RQ4: Failing address captured per error kind.
// RQ5: Single-bit error captures faulty bit position.
// RQ6: Capture freezes on first; re-arm clears.
// RQ7: Software disables buffers before reconfiguration.
// RQ8: Software never enables zero-ending bank.
// RQ9: Protected writes run with all masks.
// RQ10: Protected partial writes skip read-modify-write.
// RQ11: Refresh wins; data access stalls.
// RQ12: Refresh period selectable among four values.
// RQ13: Boot-memory cycle beats write-buffer write.
// RQ14: Boot request waits for write in progress.
// RQ15: Boot request waits for prefetch completion.
// RQ16: ECC partial unprotected write uses read-modify-write.
// RQ17: Read and check, merge, then write back.
// RQ18: Full doubleword write skips the read.
// RQ19: System reset restores all defaults.
// RQ20: Retention reset keeps configuration and refresh.
// RQ21: Retention reset lets current access finish.
// RQ22: Resets discard buffer; enables come up off.
// RQ23: Retention pin inactive until enabled.
// RQ24: Each error interrupt has own enable.
// RQ25: Interrupt holds until status flag written.
//
// Implementation choice: the APB interface to the registers.
module sdec_ctrl
  import sdec_pkg::*;
#(
  parameter int P_REF3_CYC = REF3_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              acc_valid,
  input  wire logic              acc_write,
  input  wire logic              acc_from_wb,
  input  wire logic              acc_protected,
  input  wire logic [31:0]       acc_addr,
  input  wire logic [3:0]        acc_be,
  input  wire logic [31:0]       acc_wdata,
  output logic                   acc_ack,
  output logic      [31:0]       acc_rdata,
  input  wire logic              boot_req,
  input  wire logic              boot_done,
  output logic                   boot_grant,
  output logic                   mem_cmd_valid,
  output sdec_cmd_t              mem_cmd,
  output logic      [31:0]       mem_addr,
  output logic      [31:0]       mem_wdata,
  output logic      [3:0]        byte_data_masks,
  input  wire logic              mem_done,
  input  wire logic [31:0]       mem_rdata,
  input  wire logic              ecc_single_err,
  input  wire logic              ecc_multi_err,
  input  wire logic [7:0]        ecc_syndrome,
  input  wire logic              retention_reset_pin,
  output logic                   single_error_irq,
  output logic                   multi_error_nmi,
  output logic                   write_buffer_enable,
  output logic                   prefetch_enable,
  output logic                   write_buffer_discard
);

  // ==========================================================================
  // Declarations.
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE, ST_REFRESH, ST_READ, ST_RMW_READ, ST_WRITE, ST_BOOT
  } sdec_state_t;

  sdec_state_t state;
  logic [3:0]  ecc_control;
  logic [4:0]  sdram_control;
  logic        reset_configuration;
  logic        single_error_flag;
  logic        multi_error_flag;
  logic [7:0]  faulty_bit_position;
  logic [31:0] ecc_single_error_address;
  logic [31:0] ecc_multi_error_address;
  logic        capture_armed;
  logic        ret_meta;
  logic        ret_sync;
  logic        ret_active;
  logic [31:0] cur_addr;
  logic [31:0] cur_wdata;
  logic [3:0]  cur_be;
  logic        cur_protected;
  logic [31:0] merged;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [11:0] idx;
  logic        apb_wr;
  logic        chk;
  logic        err_single;
  logic        err_multi;
  logic        rearm;
  logic        sta_wr;
  logic        ecc_on;

  sdec_refresh_if rif ();

  assign idx        = paddr[APB_AW-1:2];
  assign apb_wr     = psel && penable && pready && pwrite;
  assign sta_wr     = apb_wr && idx == IDX_ECC_STATUS;
  assign rearm      = apb_wr && idx == IDX_ECC_CONTROL && pwdata[CTL_REARM];
  assign ecc_on     = ecc_control[CTL_ECC_ENABLE];
  assign chk        = mem_done && ecc_on && (state == ST_READ || state == ST_RMW_READ);
  assign err_multi  = chk && ecc_multi_err;
  assign err_single = chk && ecc_single_err && !ecc_multi_err;
  assign rif.enable = sdram_control[SDC_REF_ENABLE];
  assign rif.rate   = sdram_control[SDC_REF_RATE_LO +: 2];

  // Byte lanes enabled by the master take new data, the rest keep the read data.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      merged[8*i +: 8] = cur_be[i] ? cur_wdata[8*i +: 8] : mem_rdata[8*i +: 8];
    end
  end

  sdec_refresh_timer #(
    .P_REF3_CYC (P_REF3_CYC)
  ) u_refresh_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .rif     (rif.timer)
  );

  // ==========================================================================
  // APB slave with one wait state.
  // ==========================================================================

  // Builds the read word and the error answer for the addressed register.
  always_comb begin
    next_prdata  = '0;
    next_pslverr = 1'b0;
    case (idx)
      IDX_ECC_CONTROL:     next_prdata = {29'h0, ecc_control[2:0]};
      IDX_ECC_STATUS:      next_prdata = {30'h0, multi_error_flag, single_error_flag}; // RQ3
      IDX_ECC_BIT_POS:     next_prdata = {24'h0, faulty_bit_position};
      IDX_ECC_SINGLE_ADDR: next_prdata = ecc_single_error_address;
      IDX_ECC_MULTI_ADDR:  next_prdata = ecc_multi_error_address;
      IDX_SDRAM_CONTROL:   next_prdata = {27'h0, sdram_control};
      IDX_RESET_CONFIG:    next_prdata = {31'h0, reset_configuration};
      default:             next_pslverr = 1'b1;
    endcase
  end

  // Answers each access in its second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && next_pslverr;
      prdata  <= (psel && penable && !pready && !pwrite) ? next_prdata : '0;
    end
  end

  // Configuration survives the retention reset; only the buffer enables drop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecc_control         <= ECC_CONTROL_RST; // RQ19
      sdram_control       <= SDRAM_CONTROL_RST;
      reset_configuration <= RESET_CONFIG_RST; // RQ23
    end else begin
      if (apb_wr && idx == IDX_ECC_CONTROL) begin
        ecc_control <= {1'b0, pwdata[2:0]}; // RQ24
      end
      if (apb_wr && idx == IDX_RESET_CONFIG) begin
        reset_configuration <= pwdata[RCF_RET_ENABLE];
      end
      if (ret_active) begin
        sdram_control[SDC_WB_ENABLE] <= 1'b0; // RQ22
        sdram_control[SDC_RA_ENABLE] <= 1'b0; // RQ22
      end else if (apb_wr && idx == IDX_SDRAM_CONTROL) begin
        sdram_control <= pwdata[4:0]; // RQ20
      end
    end
  end

  // ==========================================================================
  // Retention reset pin and buffer outputs.
  // ==========================================================================

  // Synchronises the pin and qualifies it with its enable bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ret_meta   <= 1'b0;
      ret_sync   <= 1'b0;
      ret_active <= 1'b0;
    end else begin
      ret_meta   <= retention_reset_pin;
      ret_sync   <= ret_meta;
      ret_active <= ret_sync && reset_configuration; // RQ23
    end
  end

  // Buffer enables follow the control register; pending writes are dropped in any reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_buffer_enable  <= 1'b0;
      prefetch_enable      <= 1'b0;
      write_buffer_discard <= 1'b1; // RQ22
    end else begin
      write_buffer_enable  <= sdram_control[SDC_WB_ENABLE] && !ret_active;
      prefetch_enable      <= sdram_control[SDC_RA_ENABLE] && !ret_active;
      write_buffer_discard <= ret_active; // RQ22
    end
  end

  // ==========================================================================
  // ECC error flags, capture and interrupts.
  // ==========================================================================

  // Sticky flags; a new error wins over the software clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_error_flag <= 1'b0;
      multi_error_flag  <= 1'b0;
    end else begin
      single_error_flag <= err_single || (single_error_flag && !(sta_wr && pwdata[STA_SINGLE]));
      multi_error_flag  <= err_multi || (multi_error_flag && !(sta_wr && pwdata[STA_MULTI])); // RQ25
    end
  end

  // Latches the first error only; re-arming clears what was latched.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_armed            <= 1'b1;
      faulty_bit_position      <= '0;
      ecc_single_error_address <= '0;
      ecc_multi_error_address  <= '0;
    end else if ((capture_armed || rearm) && (err_single || err_multi)) begin
      capture_armed <= 1'b0; // RQ6
      if (err_single) begin
        ecc_single_error_address <= cur_addr; // RQ4
        faulty_bit_position      <= ecc_syndrome; // RQ5
      end else begin
        ecc_multi_error_address <= cur_addr; // RQ4
      end
    end else if (rearm) begin
      capture_armed            <= 1'b1; // RQ6
      faulty_bit_position      <= '0;
      ecc_single_error_address <= '0;
      ecc_multi_error_address  <= '0;
    end
  end

  // Interrupt lines stay up while the flag is set and enabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_error_irq <= 1'b0;
      multi_error_nmi  <= 1'b0;
    end else begin
      single_error_irq <= single_error_flag && ecc_control[CTL_SINGLE_IRQ]; // RQ1
      multi_error_nmi  <= multi_error_flag && ecc_control[CTL_MULTI_IRQ]; // RQ2
    end
  end

  // ==========================================================================
  // Access sequencer.
  // ==========================================================================

  // Grants refresh, then boot memory, then data access; runs each cycle to its end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state           <= ST_IDLE; // RQ19
      mem_cmd_valid   <= 1'b0;
      mem_cmd         <= SDEC_CMD_NONE;
      mem_addr        <= '0;
      mem_wdata       <= '0;
      byte_data_masks <= '0;
      rif.ack         <= 1'b0;
      acc_ack         <= 1'b0;
      acc_rdata       <= '0;
      boot_grant      <= 1'b0;
      cur_addr        <= '0;
      cur_wdata       <= '0;
      cur_be          <= '0;
      cur_protected   <= 1'b0;
    end else begin
      mem_cmd_valid <= 1'b0;
      rif.ack       <= 1'b0;
      acc_ack       <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (rif.req) begin
            state         <= ST_REFRESH; // RQ11
            mem_cmd       <= SDEC_CMD_REFRESH; // RQ20
            mem_cmd_valid <= 1'b1;
            rif.ack       <= 1'b1;
          end else if (boot_req) begin
            state      <= ST_BOOT; // RQ13
            boot_grant <= 1'b1;
          end else if (acc_valid && !acc_ack && !ret_active) begin // RQ21
            cur_addr      <= acc_addr;
            cur_wdata     <= acc_wdata;
            cur_be        <= acc_be;
            cur_protected <= acc_protected;
            mem_addr      <= acc_addr;
            mem_cmd_valid <= 1'b1;
            if (!acc_write) begin
              state           <= ST_READ;
              mem_cmd         <= SDEC_CMD_READ;
              byte_data_masks <= '0;
            end else if (acc_protected) begin
              state           <= ST_WRITE; // RQ10
              mem_cmd         <= SDEC_CMD_WRITE;
              mem_wdata       <= acc_wdata;
              byte_data_masks <= BE_FULL; // RQ9
            end else if (ecc_on && acc_be != BE_FULL) begin
              state           <= ST_RMW_READ; // RQ16
              mem_cmd         <= SDEC_CMD_READ;
              byte_data_masks <= '0;
            end else begin
              state           <= ST_WRITE; // RQ18
              mem_cmd         <= SDEC_CMD_WRITE;
              mem_wdata       <= acc_wdata;
              byte_data_masks <= ecc_on ? 4'h0 : ~acc_be;
            end
          end
        end
        ST_REFRESH: begin
          if (mem_done) begin
            state   <= ST_IDLE;
            mem_cmd <= SDEC_CMD_NONE;
          end
        end
        ST_READ: begin
          if (mem_done) begin
            state     <= ST_IDLE; // RQ15
            mem_cmd   <= SDEC_CMD_NONE;
            acc_rdata <= mem_rdata;
            acc_ack   <= 1'b1;
          end
        end
        ST_RMW_READ: begin
          if (mem_done) begin
            state           <= ST_WRITE; // RQ17
            mem_cmd         <= SDEC_CMD_WRITE;
            mem_cmd_valid   <= 1'b1;
            mem_wdata       <= merged;
            byte_data_masks <= '0;
          end
        end
        ST_WRITE: begin
          if (mem_done) begin
            state   <= ST_IDLE; // RQ14
            mem_cmd <= SDEC_CMD_NONE;
            acc_ack <= 1'b1;
          end
        end
        ST_BOOT: begin
          if (boot_done) begin
            state      <= ST_IDLE;
            boot_grant <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  property p_refresh_first;
    @(posedge pclk) disable iff (!presetn)
      (state == ST_IDLE && rif.req && acc_valid) |=> (state == ST_REFRESH && !acc_ack);
  endproperty
  a_refresh_first: assert property (p_refresh_first) else $error("refresh lost to access"); // RQ11

  property p_boot_first;
    @(posedge pclk) disable iff (!presetn)
      (state == ST_IDLE && !rif.req && boot_req && acc_valid && acc_from_wb) |=> boot_grant;
  endproperty
  a_boot_first: assert property (p_boot_first) else $error("boot not granted first"); // RQ13

  property p_boot_waits;
    @(posedge pclk) disable iff (!presetn)
      (state inside {ST_WRITE, ST_READ, ST_RMW_READ} && !mem_done) |=> !boot_grant;
  endproperty
  a_boot_waits: assert property (p_boot_waits) else $error("boot granted mid access"); // RQ14

  property p_protect_masks;
    @(posedge pclk) disable iff (!presetn)
      (mem_cmd_valid && mem_cmd == SDEC_CMD_WRITE && cur_protected)
        |-> (byte_data_masks == BE_FULL) throughout (state == ST_WRITE)[*1];
  endproperty
  a_protect_masks: assert property (p_protect_masks) else $error("protected write unmasked"); // RQ9

  property p_no_rmw_protected;
    @(posedge pclk) disable iff (!presetn)
      (state == ST_IDLE && !rif.req && !boot_req && !ret_active && acc_valid && !acc_ack
        && acc_write && acc_protected) |=> (state == ST_WRITE);
  endproperty
  a_no_rmw_protected: assert property (p_no_rmw_protected) else $error("rmw on protect"); // RQ10

  property p_rmw_order;
    @(posedge pclk) disable iff (!presetn)
      (state == ST_RMW_READ && mem_done)
        |=> (state == ST_WRITE && mem_cmd_valid && mem_wdata == $past(merged));
  endproperty
  a_rmw_order: assert property (p_rmw_order) else $error("rmw write back wrong"); // RQ17

  property p_single_capture;
    @(posedge pclk) disable iff (!presetn)
      (err_single && capture_armed)
        |=> (single_error_flag && ecc_single_error_address == $past(cur_addr)
             && faulty_bit_position == $past(ecc_syndrome)) ##1 single_error_irq
             || !ecc_control[CTL_SINGLE_IRQ];
  endproperty
  a_single_capture: assert property (p_single_capture) else $error("single capture"); // RQ4

  property p_freeze;
    @(posedge pclk) disable iff (!presetn)
      (!capture_armed && !rearm) |=> ($stable(ecc_multi_error_address)
        && $stable(ecc_single_error_address));
  endproperty
  a_freeze: assert property (p_freeze) else $error("capture changed while frozen"); // RQ6

  property p_nmi;
    @(posedge pclk) disable iff (!presetn)
      (err_multi && ecc_control[CTL_MULTI_IRQ] && !rearm && !sta_wr) |=> ##1 multi_error_nmi;
  endproperty
  a_nmi: assert property (p_nmi) else $error("multi error nmi missing"); // RQ2

  property p_retention_hold;
    @(posedge pclk) disable iff (!presetn)
      (ret_active && state == ST_IDLE && !rif.req && !boot_req) |=> (state == ST_IDLE);
  endproperty
  a_retention_hold: assert property (p_retention_hold) else $error("access during retention"); // RQ21

endmodule : sdec_ctrl

// >>> sdec_mem_model.sv
// Behavioural SDRAM engine that answers commands and reports ECC check results.
module sdec_mem_model
  import sdec_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        mem_cmd_valid,
  input  wire sdec_cmd_t   mem_cmd,
  input  wire logic        inj_s,
  input  wire logic        inj_m,
  output logic             mem_done,
  output logic      [31:0] mem_rdata,
  output logic             ecc_single_err,
  output logic             ecc_multi_err,
  output logic      [7:0]  ecc_syndrome
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] busy = 3'h0;

  // Each command finishes three cycles after it is issued.
  always @(posedge pclk) begin
    busy <= {busy[1:0], mem_cmd_valid};
  end

  // Data and syndrome lines toggle outside a completion so no stale value lingers; the error flags stay low.
  assign mem_done       = busy[2];
  assign mem_rdata      = busy[2] ? 32'h1234_5678 : {32{pclk}};
  assign ecc_syndrome   = busy[2] ? 8'h5A : {8{pclk}};
  assign ecc_single_err = busy[2] & (mem_cmd == SDEC_CMD_READ) & inj_s;
  assign ecc_multi_err  = busy[2] & (mem_cmd == SDEC_CMD_READ) & inj_m;
endmodule // sdec_mem_model

// >>> tb.sv
// Self-checking testbench of the SDRAM ECC, protection and reset control block.
module tb
  import sdec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
  logic              acc_valid, acc_write, acc_protected, acc_ack, boot_grant, inj_s, inj_m;
  logic              mem_cmd_valid, mem_done, ecc_single_err, ecc_multi_err;
  logic              single_error_irq, multi_error_nmi, write_buffer_enable;
  logic              prefetch_enable, write_buffer_discard;
  logic              boot_req, boot_done, retention_reset_pin;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd, acc_addr, acc_wdata, acc_rdata;
  logic [31:0]       mem_addr, mem_wdata, mem_rdata;
  logic [3:0]        acc_be, byte_data_masks, masks;
  logic [7:0]        ecc_syndrome;
  sdec_cmd_t         mem_cmd;
  sdec_cmd_t         cmds[$];
  int                mismatches, compares;

  sdec_ctrl #(.P_REF3_CYC(40)) i_sdec_ctrl (.*, .acc_from_wb(1'b0));
  sdec_mem_model i_sdec_mem_model (.*);

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Log every memory command; keep the byte masks of the latest one.
  always @(posedge pclk) begin
    if (mem_cmd_valid === 1'b1) begin
      cmds.push_back(mem_cmd);
      masks = byte_data_masks;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic acc(input logic w, input logic p, input logic [3:0] be, input logic [31:0] a);
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_protected <= p;
    acc_be <= be;
    acc_addr <= a;
    do @(posedge pclk); while (acc_ack !== 1'b1);
    acc_valid <= 1'b0;
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Cut a hung run short.
  initial begin
    #100us;
    mismatches++;
    end_of_test();
  end

  // Main sequence of register and data access scenarios.
  initial begin
    {psel, penable, pwrite, acc_valid, acc_write, acc_protected, inj_s, inj_m} = 8'h00;
    {boot_req, boot_done, retention_reset_pin} = 3'h0;
    {paddr, pwdata, acc_addr, acc_be} = '0;
    acc_wdata = 32'hA5A5_A5A5;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, IDX_ECC_CONTROL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, IDX_RESET_CONFIG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h011, 32'h0);
    chk({31'h0, slv}, 32'h1);
    apb(1'b1, IDX_ECC_CONTROL, 32'h3);
    inj_s <= 1'b1;
    acc(1'b0, 1'b0, BE_FULL, 32'h100);
    repeat (2) @(posedge pclk);
    chk(single_error_irq, 1'b1);
    chk(acc_rdata, 32'h1234_5678);
    apb(1'b0, IDX_ECC_STATUS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, IDX_ECC_SINGLE_ADDR, 32'h0);
    chk(rd, 32'h100);
    apb(1'b0, IDX_ECC_BIT_POS, 32'h0);
    chk(rd, 32'h5A);
    acc(1'b0, 1'b0, BE_FULL, 32'h200);
    apb(1'b0, IDX_ECC_SINGLE_ADDR, 32'h0);
    chk(rd, 32'h100);
    apb(1'b1, IDX_ECC_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk(single_error_irq, 1'b0);
    apb(1'b1, IDX_ECC_CONTROL, 32'hF);
    apb(1'b0, IDX_ECC_SINGLE_ADDR, 32'h0);
    chk(rd, 32'h0);
    inj_s <= 1'b0;
    inj_m <= 1'b1;
    acc(1'b0, 1'b0, BE_FULL, 32'h300);
    repeat (2) @(posedge pclk);
    chk(multi_error_nmi, 1'b1);
    apb(1'b0, IDX_ECC_MULTI_ADDR, 32'h0);
    chk(rd, 32'h300);
    inj_m <= 1'b0;
    // Partial open, partial protected, then full writes.
    for (int i = 0; i < 3; i++) begin
      cmds.delete();
      acc(1'b1, i == 1, (i == 2) ? BE_FULL : 4'h4, 32'h400);
      chk(cmds.size(), (i == 0) ? 2 : 1);
      chk(cmds[0], (i == 0) ? SDEC_CMD_READ : SDEC_CMD_WRITE);
      chk(masks, (i == 1) ? BE_FULL : 4'h0);
      chk(mem_wdata, (i == 0) ? 32'h12A5_5678 : 32'hA5A5_A5A5);
      chk(mem_addr, 32'h400);
    end
    // Retention reset with both buffers enabled; buffers drop while refresh and a boot access still run.
    apb(1'b1, IDX_RESET_CONFIG, 32'h1);
    apb(1'b1, IDX_SDRAM_CONTROL, 32'h19);
    repeat (2) @(posedge pclk);
    chk({write_buffer_enable, prefetch_enable, write_buffer_discard}, 3'b110);
    retention_reset_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    chk({write_buffer_enable, prefetch_enable, write_buffer_discard}, 3'b001);
    cmds.delete();
    repeat (780) @(posedge pclk);
    chk(cmds.size() > 0 && cmds[0] == SDEC_CMD_REFRESH, 1'b1);
    apb(1'b0, IDX_SDRAM_CONTROL, 32'h0);
    chk(rd, 32'h1);
    boot_req <= 1'b1;
    do @(posedge pclk); while (boot_grant !== 1'b1);
    boot_req <= 1'b0;
    boot_done <= 1'b1;
    @(posedge pclk);
    boot_done <= 1'b0;
    @(posedge pclk);
    chk(boot_grant, 1'b0);
    retention_reset_pin <= 1'b0;
    repeat (5) @(posedge pclk);
    chk({write_buffer_enable, prefetch_enable, write_buffer_discard}, 3'b000);
    end_of_test();
  end
endmodule // tb
